// ### src/fcsf_bank.sv
// status, error and irq enable flag bank with apb slave
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "fcsf_params.svh"
module fcsf_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`FCSF_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] shifter_operating_mode,
  input wire logic [3:0] rx_load,
  input wire logic [3:0] tx_take,
  input wire logic [3:0] tx_need,
  input wire logic [3:0] match_hit,
  input wire logic [3:0] match_live,
  input wire logic [3:0] frame_err,
  input wire logic [3:0] buf_read,
  input wire logic [3:0] buf_write,
  input wire logic [7:0] timer_mode,
  input wire logic [3:0] dec_active,
  input wire logic [3:0] cnt_hi_zero,
  input wire logic [3:0] cnt_full_zero,
  output logic [3:0] shifter_irq,
  output logic event_irq
);
  import fcsf_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] shifter_flag_bits;
  logic [3:0] shifter_fault_bits;
  logic [3:0] timer_flag_bits;
  logic [3:0] shifter_flag_irq_mask;
  logic [`FCSF_EW-1:0] evt_flags;
  logic [`FCSF_EW-1:0] evt_mask;
  logic [11:0] mode_prev;
  logic [3:0] next_sflag;
  logic [3:0] next_shifter_fault_bits;
  logic [3:0] sset;
  logic [3:0] sclr;
  logic [3:0] eset;
  logic [3:0] eclr;
  logic [3:0] tset;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic rd_acc;
  logic rd_setup;
  logic hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // mode field decode
  function automatic fcsf_smode_t smode(input logic [11:0] v, input int i);
    logic [2:0] f;
    f = v[i*`FCSF_SMW +: `FCSF_SMW];
    smode = fcsf_smode_t'(f);
  endfunction

  function automatic fcsf_tmode_t tmode(input int i);
    logic [1:0] f;
    f = timer_mode[i*`FCSF_TMW +: `FCSF_TMW];
    tmode = fcsf_tmode_t'(f);
  endfunction

  function automatic logic addr_is(input logic [`FCSF_AW-1:0] a);
    addr_is = (paddr == a);
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // zero wait states; the read word is captured in the setup cycle
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  // a function's reads of paddr never wake a continuous assign, so decode in a process
  always_comb begin
    hit = addr_is(`FCSF_A_SFLAG) | addr_is(`FCSF_A_SHIFTER_FAULT_BITS) | addr_is(`FCSF_A_TFLAG)
        | addr_is(`FCSF_A_SIEN) | addr_is(`FCSF_A_EVT) | addr_is(`FCSF_A_EVTMASK);
  end
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    rd_mux = `FCSF_RST32;
    case (paddr)
      `FCSF_A_SFLAG: rd_mux[3:0] = shifter_flag_bits;
      `FCSF_A_SHIFTER_FAULT_BITS: rd_mux[3:0] = shifter_fault_bits;
      `FCSF_A_TFLAG: rd_mux[3:0] = timer_flag_bits;
      `FCSF_A_SIEN: rd_mux[3:0] = shifter_flag_irq_mask;
      `FCSF_A_EVT: rd_mux[`FCSF_EW-1:0] = evt_flags;
      `FCSF_A_EVTMASK: rd_mux[`FCSF_EW-1:0] = evt_mask;
      default: rd_mux = `FCSF_RST32;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FCSF_RST32;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // shifter flag events
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `FCSF_N; i++) begin
      fcsf_smode_t m;
      logic w1c_s;
      logic w1c_e;
      m = smode(shifter_operating_mode, i);
      w1c_s = wr_acc & addr_is(`FCSF_A_SFLAG) & pwdata[i];
      w1c_e = wr_acc & addr_is(`FCSF_A_SHIFTER_FAULT_BITS) & pwdata[i];
      sset[i] = 1'b0;
      sclr[i] = 1'b0;
      eset[i] = 1'b0;
      eclr[i] = w1c_e;
      case (m)
        FCSF_RX: begin
          sset[i] = rx_load[i];
          sclr[i] = buf_read[i] | w1c_s;
          eset[i] = (rx_load[i] & shifter_flag_bits[i]) | frame_err[i];
        end
        FCSF_TX: begin
          // transfer or mode entry sets, buffer write clears
          sset[i] = tx_take[i] | (smode(mode_prev, i) != FCSF_TX);
          sclr[i] = buf_write[i] | w1c_s;
          // shifter wants data while buffer empty
          eset[i] = tx_need[i] & shifter_flag_bits[i];
        end
        FCSF_MSTORE: begin
          sset[i] = match_hit[i];
          sclr[i] = buf_read[i] | w1c_s;
          // new match before stored one read
          eset[i] = match_hit[i] & shifter_flag_bits[i];
        end
        FCSF_MCONT: begin
          eset[i] = match_hit[i];
          eclr[i] = w1c_e | buf_read[i];
        end
        default: begin
          // write one clears in idle modes too
          sclr[i] = w1c_s;
        end
      endcase
      next_shifter_fault_bits[i] = eset[i] | (shifter_fault_bits[i] & ~eclr[i]);
      // live match result, write one ignored
      if (m == FCSF_MCONT) begin
        next_sflag[i] = match_live[i];
      end else begin
        next_sflag[i] = sset[i] | (shifter_flag_bits[i] & ~sclr[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shifter_flag_bits <= `FCSF_RST4;
      shifter_fault_bits <= `FCSF_RST4;
      mode_prev <= {`FCSF_N{FCSF_OFF}};
    end else begin
      shifter_flag_bits <= next_sflag;
      shifter_fault_bits <= next_shifter_fault_bits;
      mode_prev <= shifter_operating_mode;
    end
  end

  // ----------------------------------------
  // timer flags
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < `FCSF_N; i++) begin
      case (tmode(i))
        FCSF_TBAUD: tset[i] = dec_active[i] & cnt_hi_zero[i];
        FCSF_TPWM: tset[i] = dec_active[i] & cnt_hi_zero[i];
        FCSF_T16: tset[i] = dec_active[i] & cnt_full_zero[i];
        default: tset[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flag_bits <= `FCSF_RST4;
    end else if (wr_acc & addr_is(`FCSF_A_TFLAG)) begin
      // sticky, write one clears, set wins
      timer_flag_bits <= tset | (timer_flag_bits & ~pwdata[3:0]);
    end else begin
      timer_flag_bits <= tset | timer_flag_bits;
    end
  end

  // ----------------------------------------
  // enables and event interrupt
  // ----------------------------------------
  // upper write bits are dropped; software must keep them zero anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shifter_flag_irq_mask <= `FCSF_RST4;
    end else if (wr_acc & addr_is(`FCSF_A_SIEN)) begin
      shifter_flag_irq_mask <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= `FCSF_RST8;
    end else if (wr_acc & addr_is(`FCSF_A_EVTMASK)) begin
      evt_mask <= pwdata[`FCSF_EW-1:0];
    end
  end

  // read clears only what the read returned, so a late event survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_flags <= `FCSF_RST8;
    end else if (rd_acc & addr_is(`FCSF_A_EVT)) begin
      evt_flags <= {tset, eset} | (evt_flags & ~prdata[`FCSF_EW-1:0]);
    end else begin
      evt_flags <= {tset, eset} | evt_flags;
    end
  end

  assign shifter_irq = shifter_flag_bits & shifter_flag_irq_mask;
  assign event_irq = |(evt_flags & evt_mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic w1c_s0;
  logic w1c_e0;
  logic w1c_t0;
  fcsf_smode_t mode0;
  // helpers in a process, so that the paddr read inside addr_is is followed
  always_comb begin
    w1c_s0 = wr_acc & addr_is(`FCSF_A_SFLAG) & pwdata[0];
    w1c_e0 = wr_acc & addr_is(`FCSF_A_SHIFTER_FAULT_BITS) & pwdata[0];
    w1c_t0 = wr_acc & addr_is(`FCSF_A_TFLAG) & pwdata[0];
    mode0 = smode(shifter_operating_mode, 0);
  end

  // ----------------------------------------
  // shifter status checks
  // ----------------------------------------
  a_rx_load_set: assert property (
    mode0 == FCSF_RX && rx_load[0] |=> shifter_flag_bits[0])
    else $error("receive load did not set flag");
  a_rx_read_clr: assert property (
    mode0 == FCSF_RX && buf_read[0] && !rx_load[0]
    |=> !shifter_flag_bits[0])
    else $error("receive read did not clear flag");
  a_tx_entry_set: assert property (
    mode0 == FCSF_TX && smode(mode_prev, 0) != FCSF_TX
    |=> shifter_flag_bits[0])
    else $error("transmit entry did not set flag");
  a_tx_write_clr: assert property (
    mode0 == FCSF_TX && smode(mode_prev, 0) == FCSF_TX
    && buf_write[0] && !tx_take[0]
    |=> !shifter_flag_bits[0])
    else $error("transmit write did not clear flag");
  a_mstore_set: assert property (
    mode0 == FCSF_MSTORE && match_hit[0] |=> shifter_flag_bits[0])
    else $error("match store did not set flag");
  a_mstore_read_clr: assert property (
    mode0 == FCSF_MSTORE && buf_read[0] && !match_hit[0]
    |=> !shifter_flag_bits[0])
    else $error("match store read did not clear flag");
  a_mcont_live: assert property (
    mode0 == FCSF_MCONT
    |=> shifter_flag_bits[0] == $past(match_live[0]))
    else $error("continuous flag not live");
  a_w1c_sflag: assert property (
    w1c_s0 && mode0 == FCSF_RX && !rx_load[0]
    |=> !shifter_flag_bits[0])
    else $error("write one did not clear flag");
  a_mcont_keeps_flag: assert property (
    w1c_s0 && mode0 == FCSF_MCONT && match_live[0]
    |=> shifter_flag_bits[0])
    else $error("write one cleared a live match");
  a_off_no_set: assert property (
    mode0 == FCSF_OFF && !shifter_flag_bits[0]
    |=> !shifter_flag_bits[0])
    else $error("disabled shifter raised its flag");
  a_irq_gate: assert property (
    shifter_irq[0] |-> shifter_flag_bits[0] && shifter_flag_irq_mask[0])
    else $error("irq without flag and enable");
  a_set_wins: assert property (
    w1c_s0 && mode0 == FCSF_RX && rx_load[0]
    |=> shifter_flag_bits[0])
    else $error("clear beat a set");

  // ----------------------------------------
  // shifter error checks
  // ----------------------------------------
  a_rx_frame_err: assert property (
    mode0 == FCSF_RX && frame_err[0] |=> shifter_fault_bits[0])
    else $error("framing error not flagged");
  a_rx_overrun: assert property (
    mode0 == FCSF_RX && rx_load[0] && shifter_flag_bits[0]
    |=> shifter_fault_bits[0])
    else $error("receive overrun not flagged");
  a_tx_underrun: assert property (
    mode0 == FCSF_TX && tx_need[0] && shifter_flag_bits[0]
    |=> shifter_fault_bits[0])
    else $error("transmit underrun not flagged");
  a_mstore_err: assert property (
    mode0 == FCSF_MSTORE && match_hit[0] && shifter_flag_bits[0]
    |=> shifter_fault_bits[0])
    else $error("unread match not flagged");
  a_mcont_err: assert property (
    mode0 == FCSF_MCONT && match_hit[0]
    |=> shifter_fault_bits[0])
    else $error("continuous match error not flagged");
  a_mcont_read_clr: assert property (
    mode0 == FCSF_MCONT && buf_read[0] && !match_hit[0]
    |=> !shifter_fault_bits[0])
    else $error("buffer read did not clear error");
  a_err_w1c: assert property (
    w1c_e0 && mode0 == FCSF_OFF
    |=> !shifter_fault_bits[0])
    else $error("write one did not clear error");

  // ----------------------------------------
  // timer checks
  // ----------------------------------------
  a_baud_set: assert property (
    tmode(0) == FCSF_TBAUD && dec_active[0] && cnt_hi_zero[0]
    |=> timer_flag_bits[0])
    else $error("baud timer zero not flagged");
  a_pwm_set: assert property (
    tmode(0) == FCSF_TPWM && dec_active[0] && cnt_hi_zero[0]
    |=> timer_flag_bits[0])
    else $error("pwm timer zero not flagged");
  a_t16_set: assert property (
    tmode(0) == FCSF_T16 && dec_active[0] && cnt_full_zero[0] |=> timer_flag_bits[0])
    else $error("timer zero not flagged");
  a_tflag_sticky: assert property (
    timer_flag_bits[0] && !w1c_t0
    |=> timer_flag_bits[0])
    else $error("timer flag dropped");
  a_tflag_w1c: assert property (
    w1c_t0 && tmode(0) == FCSF_TOFF
    |=> !timer_flag_bits[0])
    else $error("write one did not clear timer flag");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_rx_flow: cover property (rx_load[0] ##[1:20] buf_read[0]);
  c_irq: cover property (shifter_irq[0]);
  c_evt: cover property (event_irq ##[1:20] !event_irq);
  c_underrun: cover property (mode0 == FCSF_TX && tx_need[0] && shifter_flag_bits[0]);
  c_tflag_w1c: cover property (w1c_t0 && timer_flag_bits[0]);
endmodule
`default_nettype wire

// ### src/fcsf_params.svh
// constants and register map of the flag bank
`ifndef FCSF_PARAMS_SVH
`define FCSF_PARAMS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define FCSF_AW 12
`define FCSF_A_SFLAG 12'h008
`define FCSF_A_SHIFTER_FAULT_BITS 12'h00c
`define FCSF_A_TFLAG 12'h010
`define FCSF_A_SIEN 12'h018
`define FCSF_A_EVT 12'h030
`define FCSF_A_EVTMASK 12'h034
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define FCSF_N 4
`define FCSF_EW 8
`define FCSF_SMW 3
`define FCSF_TMW 2
`define FCSF_RST4 4'h0
`define FCSF_RST8 8'h00
`define FCSF_RST32 32'h0000_0000
`endif

// ### src/fcsf_pkg.sv
// types of the flag bank
package fcsf_pkg;
  typedef enum logic [2:0] {
    FCSF_OFF = 3'b000,
    FCSF_RX = 3'b001,
    FCSF_TX = 3'b010,
    FCSF_MSTORE = 3'b100,
    FCSF_MCONT = 3'b101
  } fcsf_smode_t;
  typedef enum logic [1:0] {
    FCSF_TOFF = 2'b00,
    FCSF_TBAUD = 2'b01,
    FCSF_TPWM = 2'b10,
    FCSF_T16 = 2'b11
  } fcsf_tmode_t;
endpackage

// ### verification/fcsf_bank_tb_top.sv
// self-checking bench with a reference model of the flag bank
`timescale 1ns/100ps
`default_nettype none
`include "fcsf_params.svh"
module fcsf_bank_tb_top;
  import fcsf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, event_irq, rnd_on;
  logic [`FCSF_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] smode;
  logic [7:0] tmode;
  logic [3:0] rx_load, tx_take, tx_need, match_hit, match_live, frame_err;
  logic [3:0] buf_read, buf_write, dec_active, hi_zero, full_zero, shifter_irq;
  logic [3:0] m_sf, m_se, m_tf, m_ien;
  logic [7:0] m_ev, m_evm;
  logic [31:0] m_cap;
  logic [2:0] m_prev [4];
  logic [2:0] mtab [8] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
  logic [11:0] atab [7] = '{12'h008, 12'h00c, 12'h010, 12'h018, 12'h030, 12'h034, 12'h03c};
  int num_errors, checked;
  logic [11:0] ra;
  fcsf_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shifter_operating_mode(smode), .rx_load(rx_load),
    .tx_take(tx_take), .tx_need(tx_need), .match_hit(match_hit), .match_live(match_live),
    .frame_err(frame_err), .buf_read(buf_read), .buf_write(buf_write), .timer_mode(tmode),
    .dec_active(dec_active), .cnt_hi_zero(hi_zero), .cnt_full_zero(full_zero),
    .shifter_irq(shifter_irq), .event_irq(event_irq));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [31:0] rdval(input logic [11:0] a);
    case (a)
      `FCSF_A_SFLAG: rdval = {28'h0, m_sf};
      `FCSF_A_SHIFTER_FAULT_BITS: rdval = {28'h0, m_se};
      `FCSF_A_TFLAG: rdval = {28'h0, m_tf};
      `FCSF_A_SIEN: rdval = {28'h0, m_ien};
      `FCSF_A_EVT: rdval = {24'h0, m_ev};
      `FCSF_A_EVTMASK: rdval = {24'h0, m_evm};
      default: rdval = 32'h0;
    endcase
  endfunction
  // software keeps unused upper bits zero
  function automatic logic [31:0] legal(input logic [11:0] a);
    legal = (a == `FCSF_A_EVT || a == `FCSF_A_EVTMASK) ? 32'h0000_00ff : 32'h0000_000f;
  endfunction
  always @(posedge pclk or negedge presetn) begin
    logic [3:0] ss, sc, es, ec, ts, tc, nsf;
    logic [7:0] evc;
    logic wr;
    if (!presetn) begin
      {m_sf, m_se, m_tf, m_ien, m_ev, m_evm, m_cap} = '0;
      m_prev = '{default: 3'b000};
    end else begin
      wr = psel && penable && pwrite;
      sc = (wr && paddr == `FCSF_A_SFLAG) ? pwdata[3:0] : 4'h0;
      ec = (wr && paddr == `FCSF_A_SHIFTER_FAULT_BITS) ? pwdata[3:0] : 4'h0;
      tc = (wr && paddr == `FCSF_A_TFLAG) ? pwdata[3:0] : 4'h0;
      evc = (psel && penable && !pwrite && paddr == `FCSF_A_EVT) ? m_cap[7:0] : 8'h0;
      if (psel && !penable && !pwrite) m_cap = rdval(paddr);
      {ss, es, ts} = '0;
      nsf = m_sf;
      for (int i = 0; i < 4; i++) begin
        case (smode[i*3+:3])
          FCSF_RX: begin
            ss[i] = rx_load[i]; sc[i] |= buf_read[i];
            es[i] = frame_err[i] | (rx_load[i] & m_sf[i]);
          end
          FCSF_TX: begin
            ss[i] = tx_take[i] | (m_prev[i] != FCSF_TX); sc[i] |= buf_write[i];
            es[i] = tx_need[i] & m_sf[i];
          end
          FCSF_MSTORE: begin
            ss[i] = match_hit[i]; sc[i] |= buf_read[i]; es[i] = match_hit[i] & m_sf[i];
          end
          FCSF_MCONT: begin
            ec[i] |= buf_read[i]; es[i] = match_hit[i];
          end
          default: ;
        endcase
        if (smode[i*3+:3] == FCSF_MCONT) nsf[i] = match_live[i];
        else nsf[i] = (m_sf[i] & ~sc[i]) | ss[i];
        case (tmode[i*2+:2])
          2'b01, 2'b10: ts[i] = dec_active[i] & hi_zero[i];
          2'b11: ts[i] = dec_active[i] & full_zero[i];
          default: ;
        endcase
        m_prev[i] = smode[i*3+:3];
      end
      m_sf = nsf;
      m_se = (m_se & ~ec) | es;
      m_tf = (m_tf & ~tc) | ts;
      m_ev = (m_ev & ~evc) | {ts, es};
      if (wr && paddr == `FCSF_A_SIEN) m_ien = pwdata[3:0];
      if (wr && paddr == `FCSF_A_EVTMASK) m_evm = pwdata[7:0];
    end
  end
  // ----------------------------------------
  // checks and drivers
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk(1'b0, "ready never came");
      give_verdict;
    end else begin
      chk(pslverr === (a == 12'h03c), "slave error flag wrong");
      if (!wr) chk(prdata === m_cap, "read data wrong");
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  always @(negedge pclk) begin
    chk(shifter_irq === (m_sf & m_ien), "shifter irq wrong");
    chk(event_irq === |(m_ev & m_evm), "event irq wrong");
  end
  always @(posedge pclk) begin
    if (rnd_on) begin
      {rx_load, tx_take, tx_need, match_hit} <= 16'($urandom) & 16'($urandom);
      {match_live, frame_err, buf_read, buf_write} <= 16'($urandom) & 16'($urandom);
      {dec_active, hi_zero, full_zero} <= 12'($urandom);
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    chk(1'b0, "run too long");
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, smode, tmode, rnd_on} = '0;
    {rx_load, tx_take, tx_need, match_hit, match_live, frame_err} = '0;
    {buf_read, buf_write, dec_active, hi_zero, full_zero} = '0;
    num_errors = 0;
    checked = 0;
    void'($urandom(32'ha51fa54e));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) apb(1'b0, atab[k], 32'h0);
    for (int k = 0; k < 7; k++) apb(1'b1, atab[k], legal(atab[k]));
    for (int r = 0; r < 120; r++) begin
      for (int i = 0; i < 4; i++) smode[i*3+:3] <= mtab[$urandom % 8];
      tmode <= 8'($urandom);
      rnd_on <= 1'b1;
      repeat (4) begin
        ra = atab[$urandom % 7];
        apb(1'($urandom), ra, $urandom & legal(ra));
      end
      if (r == 60) begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
      end
    end
    rnd_on <= 1'b0;
    for (int k = 0; k < 7; k++) apb(1'b0, atab[k], 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire
